// ===== hw/adcss_sweep_sequencer.sv
// How it works
// - Sweep mode 1 repeats, priority pins get extra slots
// - Whole priority group alternates with each other pin
// - Software trigger starts on start flag write
// - External trigger starts on falling edge after set
// - Sweep 1 runs until flag cleared, no interrupt
// - Priority group is one to four pins
// - Result lands in its channel's result register
// - Ten-bit result bits 0-9, eight-bit bits 0-7
// - Sample-and-hold: 28 or 33 cycles per channel
// - Extended inputs usable in one-shot and repeat
// - Extended results go to registers 0 and 1
// - Op-amp mode routes out first, converts second
// - Alternative input groups behave like primary group
// - No joint reference/start set, no disconnect busy
`timescale 1ns/1ps
`default_nettype none
module adcss_sweep_sequencer
  import adcss_pkg::*;
#(
  parameter int unsigned NOSH_CYCLES_8  = 40,  // Per-channel cycles, 8-bit, no sample-and-hold
  parameter int unsigned NOSH_CYCLES_10 = 48   // Per-channel cycles, 10-bit, no sample-and-hold
) (
  input  wire logic                      ref_clk,              // Converter clock, 50 MHz
  input  wire logic                      reset,                // Async reset, high
  input  wire logic                      start_write,          // Software writes start flag
  input  wire logic                      start_wdata,          // Value written to start flag
  input  wire logic                      ref_write,            // Software writes reference bit
  input  wire logic                      ref_wdata,            // Value written to reference bit
  input  wire logic                      trigger_select,       // 0 software, 1 external pin
  input  wire logic [1:0]                op_mode,              // One-shot, repeat, sweep 1
  input  wire logic [2:0]                chan_select,          // Channel for one-shot/repeat
  input  wire logic                      sweep_pin_count_hi,   // Priority pin count, high
  input  wire logic                      sweep_pin_count_lo,   // Priority pin count, low
  input  wire logic                      input_group_select_hi, // Input group, high
  input  wire logic                      input_group_select_lo, // Input group, low
  input  wire logic                      resolution_10bit,     // 1 ten-bit, 0 eight-bit
  input  wire logic                      sample_hold_enable,   // Sample-and-hold on
  input  wire logic                      ext_input_mode_hi,    // Extended input mode, high
  input  wire logic                      ext_input_mode_lo,    // Extended input mode, low
  input  wire logic                      external_trigger_pin, // External trigger level
  input  wire logic [ADCSS_RESULT_W-1:0] adc_code,             // Comparator result at end
  input  wire logic [2:0]                result_rd_addr,       // Result register to read
  output var  logic [ADCSS_RESULT_W-1:0] conversion_result_n,  // Read result, registered
  output var  logic                      conversion_start_flag, // Start flag state
  output var  logic                      reference_connect,    // Reference connected
  output var  logic                      busy,                 // Conversion running
  output var  logic                      sample_strobe,        // First cycle of a channel
  output var  logic [2:0]                mux_channel,          // Channel at the mux
  output var  logic [1:0]                mux_group,            // Input group at the mux
  output var  logic [1:0]                mux_source,           // Pin or extended input
  output var  logic                      opamp_route_out,      // Channel out on first ext pin
  output var  logic                      result_written        // Pulse when a result stored
);

  initial begin
    if (NOSH_CYCLES_8 < 2 || NOSH_CYCLES_10 < 2 ||
        NOSH_CYCLES_8 >= (1 << ADCSS_CNT_W) || NOSH_CYCLES_10 >= (1 << ADCSS_CNT_W)) begin
      $error("adcss_sweep_sequencer: conversion cycle counts out of range");
    end
  end

  localparam logic [ADCSS_CNT_W-1:0] SH_LEN_8    = ADCSS_CNT_W'(ADCSS_SH_CYCLES_8);
  localparam logic [ADCSS_CNT_W-1:0] SH_LEN_10   = ADCSS_CNT_W'(ADCSS_SH_CYCLES_10);
  localparam logic [ADCSS_CNT_W-1:0] NOSH_LEN_8  = ADCSS_CNT_W'(NOSH_CYCLES_8);
  localparam logic [ADCSS_CNT_W-1:0] NOSH_LEN_10 = ADCSS_CNT_W'(NOSH_CYCLES_10);
  localparam logic [ADCSS_CNT_W-1:0] CNT_ONE     = ADCSS_CNT_W'(1);

  function automatic logic [ADCSS_CNT_W-1:0] conv_len(input logic sh, input logic wide);
    if (sh) begin
      conv_len = wide ? SH_LEN_10 : SH_LEN_8;
    end else begin
      conv_len = wide ? NOSH_LEN_10 : NOSH_LEN_8;
    end
  endfunction

  // Next non-priority channel, wrapping to the first one past the group
  function automatic logic [2:0] next_np(input logic [2:0] np, input logic [2:0] prio);
    if (np == ADCSS_CHAN_LAST) begin
      next_np = prio;
    end else begin
      next_np = np + ADCSS_CHAN_STEP;
    end
  endfunction

  logic [1:0]  pin_count;
  logic [2:0]  prio_pins;
  logic [1:0]  ext_mode;
  logic        ext_allowed;
  logic        sweep1;

  always_comb begin
    pin_count   = {sweep_pin_count_hi, sweep_pin_count_lo};
    prio_pins   = {1'b0, pin_count} + ADCSS_PRIO_BASE;
    ext_mode    = {ext_input_mode_hi, ext_input_mode_lo};
    sweep1      = (op_mode == ADCSS_MODE_SWEEP1);
    ext_allowed = (op_mode == ADCSS_MODE_ONE_SHOT) || (op_mode == ADCSS_MODE_REPEAT);
  end

  adcss_state_t            state;
  adcss_state_t            next_state;
  logic [ADCSS_CNT_W-1:0]  cnt;
  logic [ADCSS_CNT_W-1:0]  next_cnt;
  logic [2:0]              prio_idx;
  logic [2:0]              next_prio_idx;
  logic [2:0]              np_idx;
  logic [2:0]              next_np_idx;
  logic                    in_prio;
  logic                    next_in_prio;
  logic                    trig_prev;
  logic                    next_trig_prev;
  logic                    next_flag;
  logic                    next_ref;
  logic [2:0]              cur_chan;
  logic                    conv_last;
  logic                    wr_en;
  logic [2:0]              wr_addr;
  logic [ADCSS_RESULT_W-1:0] wr_data;
  logic                    next_result_written;
  logic                    sw_set;
  logic                    sw_clear;
  logic                    hw_clear;
  logic                    trig_fall;

  always_comb begin
    cur_chan = chan_select;
    if (sweep1) begin
      cur_chan = in_prio ? prio_idx : np_idx;
    end
  end

  always_comb begin
    conv_last = (state == ADCSS_CONVERT) &&
                (cnt == conv_len(sample_hold_enable, resolution_10bit) - CNT_ONE);
    trig_fall = trig_prev && !external_trigger_pin;
    // A set joined with a reference connect write is refused while disconnected; a lone set is taken
    sw_set    = start_write && start_wdata &&
                !(ref_write && ref_wdata && !reference_connect);
    sw_clear  = start_write && !start_wdata;
    hw_clear  = conv_last && (op_mode == ADCSS_MODE_ONE_SHOT);
  end

  // Start flag and reference bit
  always_comb begin
    next_flag = conversion_start_flag;
    if (sw_clear || hw_clear) begin
      next_flag = 1'b0;
    end
    if (sw_set) begin
      next_flag = 1'b1;
    end
    next_ref = reference_connect;
    if (ref_write) begin
      // Disconnect is ignored while converting
      if (ref_wdata || !busy) begin
        next_ref = ref_wdata;
      end
    end
    next_trig_prev = external_trigger_pin;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      conversion_start_flag <= 1'b0;
      reference_connect     <= 1'b0;
      trig_prev             <= 1'b1;
    end else begin
      conversion_start_flag <= next_flag;
      reference_connect     <= next_ref;
      trig_prev             <= next_trig_prev;
    end
  end

  // Sequencer
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_prio_idx = prio_idx;
    next_np_idx   = np_idx;
    next_in_prio  = in_prio;
    case (state)
      ADCSS_IDLE: begin
        next_cnt      = '0;
        next_prio_idx = ADCSS_CHAN_FIRST;
        next_np_idx   = prio_pins;
        next_in_prio  = 1'b1;
        if (conversion_start_flag) begin
          next_state = trigger_select ? ADCSS_WAIT_TRIG : ADCSS_CONVERT;
        end
      end
      ADCSS_WAIT_TRIG: begin
        if (!conversion_start_flag) begin
          next_state = ADCSS_IDLE;
        end else if (trig_fall) begin
          next_state = ADCSS_CONVERT;
        end
      end
      ADCSS_CONVERT: begin
        if (!conversion_start_flag) begin
          next_state = ADCSS_IDLE;
        end else if (conv_last) begin
          next_cnt = '0;
          if (op_mode == ADCSS_MODE_ONE_SHOT) begin
            next_state = ADCSS_IDLE;
          end else if (sweep1) begin
            if (in_prio && (prio_idx + ADCSS_CHAN_STEP < prio_pins)) begin
              next_prio_idx = prio_idx + ADCSS_CHAN_STEP;
            end else if (in_prio) begin
              next_in_prio = 1'b0;
            end else begin
              next_in_prio  = 1'b1;
              next_prio_idx = ADCSS_CHAN_FIRST;
              next_np_idx   = next_np(np_idx, prio_pins);
            end
          end
        end else begin
          next_cnt = cnt + CNT_ONE;
        end
      end
      default: begin
        next_state = ADCSS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state    <= ADCSS_IDLE;
      cnt      <= '0;
      prio_idx <= ADCSS_CHAN_FIRST;
      np_idx   <= ADCSS_CHAN_FIRST;
      in_prio  <= 1'b1;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      prio_idx <= next_prio_idx;
      np_idx   <= next_np_idx;
      in_prio  <= next_in_prio;
    end
  end

  // Result placement
  always_comb begin
    wr_en   = conv_last && conversion_start_flag;
    wr_addr = cur_chan;
    if (ext_allowed && ext_mode == ADCSS_EXT_FIRST) begin
      wr_addr = ADCSS_EXT_FIRST_SLOT;
    end else if (ext_allowed && ext_mode == ADCSS_EXT_SECOND) begin
      wr_addr = ADCSS_EXT_SECOND_SLOT;
    end
    if (resolution_10bit) begin
      wr_data = adc_code;
    end else begin
      wr_data = {{(ADCSS_RESULT_W-ADCSS_NARROW_W){1'b0}}, adc_code[ADCSS_NARROW_W-1:0]};
    end
    next_result_written = wr_en;
  end

  adcss_result_mem #(
    .WIDTH (ADCSS_RESULT_W),
    .DEPTH (ADCSS_CHANNELS),
    .AW    (ADCSS_CHAN_W)
  ) u_results (
    .ref_clk (ref_clk),
    .reset   (reset),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (result_rd_addr),
    .rd_data (conversion_result_n)
  );

  // Mux steering; the group field applies to every mode alike
  logic [2:0] next_mux_channel;
  logic [1:0] next_mux_group;
  logic [1:0] next_mux_source;
  logic       next_opamp;

  always_comb begin
    next_mux_channel = cur_chan;
    next_mux_group   = {input_group_select_hi, input_group_select_lo};
    next_mux_source  = ADCSS_SRC_PIN;
    next_opamp       = 1'b0;
    if (ext_allowed) begin
      case (ext_mode)
        ADCSS_EXT_FIRST:  next_mux_source = ADCSS_SRC_EXT_FIRST;
        ADCSS_EXT_SECOND: next_mux_source = ADCSS_SRC_EXT_SECOND;
        ADCSS_EXT_OPAMP: begin
          next_mux_source = ADCSS_SRC_EXT_SECOND;
          next_opamp      = 1'b1;
        end
        default:          next_mux_source = ADCSS_SRC_PIN;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mux_channel    <= ADCSS_CHAN_FIRST;
      mux_group      <= 2'h0;
      mux_source     <= ADCSS_SRC_PIN;
      opamp_route_out <= 1'b0;
      result_written <= 1'b0;
    end else begin
      mux_channel    <= next_mux_channel;
      mux_group      <= next_mux_group;
      mux_source     <= next_mux_source;
      opamp_route_out <= next_opamp;
      result_written <= next_result_written;
    end
  end

  // Handshake outputs, combinational; sweep mode 1 raises no request
  always_comb begin
    busy          = (state == ADCSS_CONVERT);
    sample_strobe = busy && (cnt == '0);
  end

endmodule
`default_nettype wire

// ===== common/adcss_pkg.sv
`default_nettype none
package adcss_pkg;

  localparam int unsigned ADCSS_CHANNELS     = 8;
  localparam int unsigned ADCSS_CHAN_W       = 3;
  localparam int unsigned ADCSS_RESULT_W     = 10;
  localparam int unsigned ADCSS_NARROW_W     = 8;
  localparam int unsigned ADCSS_CNT_W        = 8;

  // Cycles per channel with sample-and-hold on
  localparam int unsigned ADCSS_SH_CYCLES_8  = 28;
  localparam int unsigned ADCSS_SH_CYCLES_10 = 33;

  // Sweep pin count field: value 00..11 gives 1..4 priority pins
  localparam logic [2:0] ADCSS_PRIO_BASE     = 3'h1;
  localparam logic [2:0] ADCSS_CHAN_FIRST    = 3'h0;
  localparam logic [2:0] ADCSS_CHAN_LAST     = 3'h7;
  localparam logic [2:0] ADCSS_CHAN_STEP     = 3'h1;

  // Result slots of the two extended inputs
  localparam logic [2:0] ADCSS_EXT_FIRST_SLOT  = 3'h0;
  localparam logic [2:0] ADCSS_EXT_SECOND_SLOT = 3'h1;

  // Extended input mode select field
  localparam logic [1:0] ADCSS_EXT_NONE      = 2'h0;
  localparam logic [1:0] ADCSS_EXT_FIRST     = 2'h1;
  localparam logic [1:0] ADCSS_EXT_SECOND    = 2'h2;
  localparam logic [1:0] ADCSS_EXT_OPAMP     = 2'h3;

  // Analog source select driven to the mux
  localparam logic [1:0] ADCSS_SRC_PIN       = 2'h0;
  localparam logic [1:0] ADCSS_SRC_EXT_FIRST = 2'h1;
  localparam logic [1:0] ADCSS_SRC_EXT_SECOND = 2'h2;

  // Operation mode field
  localparam logic [1:0] ADCSS_MODE_ONE_SHOT = 2'h0;
  localparam logic [1:0] ADCSS_MODE_REPEAT   = 2'h1;
  localparam logic [1:0] ADCSS_MODE_SWEEP1   = 2'h2;

  typedef enum logic [1:0] {
    ADCSS_IDLE,
    ADCSS_WAIT_TRIG,
    ADCSS_CONVERT
  } adcss_state_t;

endpackage
`default_nettype wire

// ===== hw/adcss_result_mem.sv
`timescale 1ns/1ps
`default_nettype none
module adcss_result_mem #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW    = 3
) (
  input  wire logic             ref_clk,  // Converter clock
  input  wire logic             reset,    // Async reset, high
  input  wire logic             wr_en,    // Write strobe
  input  wire logic [AW-1:0]    wr_addr,  // Write slot
  input  wire logic [WIDTH-1:0] wr_data,  // Write value
  input  wire logic [AW-1:0]    rd_addr,  // Read slot
  output var  logic [WIDTH-1:0] rd_data   // Registered read value
);

  initial begin
    if (DEPTH > (1 << AW)) begin
      $error("adcss_result_mem: DEPTH exceeds address range");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_rd_data;

  always_comb begin
    next_rd_data = mem[rd_addr];
  end

  // No reset on the array itself; only the read register is cleared
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_data <= '0;
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule
`default_nettype wire

// ===== tb/adcss_sweep_checker.sv
`timescale 1ns/1ps
`default_nettype none
module adcss_sweep_checker
  import adcss_pkg::*;
#(
  parameter int unsigned NOSH_CYCLES_8  = 40,
  parameter int unsigned NOSH_CYCLES_10 = 48
) (
  input wire logic       ref_clk,               // Clock
  input wire logic       reset,                 // Reset
  input wire logic       start_write,           // Flag write
  input wire logic       start_wdata,           // Flag value
  input wire logic       ref_write,             // Ref write
  input wire logic       ref_wdata,             // Ref value
  input wire logic       trigger_select,        // Trigger kind
  input wire logic [1:0] op_mode,               // Mode
  input wire logic       resolution_10bit,      // Width
  input wire logic       sample_hold_enable,    // S&H
  input wire logic       external_trigger_pin,  // Trigger pin
  input wire logic       conversion_start_flag, // Flag
  input wire logic       reference_connect,     // Ref state
  input wire logic       busy,                  // Running
  input wire logic       sample_strobe          // Channel start
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [7:0]  gap;
  logic [7:0]  next_gap;
  int unsigned want;
  // Gap is zero when idle, so the first strobe of a run is never judged
  always_comb begin
    next_gap = gap;
    if (!busy) begin
      next_gap = 8'h00;
    end else if (sample_strobe) begin
      next_gap = 8'h01;
    end else if (gap != 8'h00) begin
      next_gap = gap + 8'h01;
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      gap <= 8'h00;
    end else begin
      gap <= next_gap;
    end
  end
  assign want = sample_hold_enable ?
                (resolution_10bit ? ADCSS_SH_CYCLES_10 : ADCSS_SH_CYCLES_8) :
                (resolution_10bit ? NOSH_CYCLES_10 : NOSH_CYCLES_8);
  chan_time_a: assert property (sample_strobe && gap != 8'h00 |-> gap == want[7:0])
    else $error("channel length wrong");
  sw_start_a: assert property (start_write && start_wdata && !trigger_select && !busy &&
    !conversion_start_flag && !(ref_write && ref_wdata) |=>
    conversion_start_flag ##1 (busy && sample_strobe)) else $error("software start late");
  joint_set_a: assert property (start_write && start_wdata && ref_write && ref_wdata &&
    !reference_connect |=> !conversion_start_flag) else $error("joint set accepted");
  ref_hold_a: assert property (busy && reference_connect |=> reference_connect)
    else $error("reference dropped while busy");
  trig_wait_a: assert property (conversion_start_flag && trigger_select && !busy &&
    external_trigger_pin && !start_write |=> !busy) else $error("start without falling edge");
  trig_go_a: assert property ($fell(external_trigger_pin) && conversion_start_flag &&
    trigger_select && !busy |-> ##[1:2] busy) else $error("falling edge ignored");
  sweep_run_a: assert property (busy && op_mode == ADCSS_MODE_SWEEP1 &&
    conversion_start_flag && !start_write |=> busy) else $error("sweep stopped by itself");
  abort_a: assert property (start_write && !start_wdata && conversion_start_flag |=>
    !conversion_start_flag ##[0:1] !busy) else $error("clear did not halt");
  stop_idle_a: assert property ((!conversion_start_flag)[*2] |-> !busy)
    else $error("busy without flag");
  cover property (busy && op_mode == ADCSS_MODE_SWEEP1);
  cover property ($fell(external_trigger_pin) && conversion_start_flag);
  cover property (sample_strobe && gap != 8'h00);
endmodule
bind adcss_sweep_sequencer adcss_sweep_checker #(
  .NOSH_CYCLES_8(NOSH_CYCLES_8),
  .NOSH_CYCLES_10(NOSH_CYCLES_10)
) u_chk (
  .ref_clk(ref_clk),
  .reset(reset),
  .start_write(start_write),
  .start_wdata(start_wdata),
  .ref_write(ref_write),
  .ref_wdata(ref_wdata),
  .trigger_select(trigger_select),
  .op_mode(op_mode),
  .resolution_10bit(resolution_10bit),
  .sample_hold_enable(sample_hold_enable),
  .external_trigger_pin(external_trigger_pin),
  .conversion_start_flag(conversion_start_flag),
  .reference_connect(reference_connect),
  .busy(busy),
  .sample_strobe(sample_strobe)
);
`default_nettype wire

// ===== tb/adcss_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module adcss_far_side
  import adcss_pkg::*;
(
  input  wire logic                      ref_clk,              // Clock
  input  wire logic                      fire,                 // Request a trigger
  input  wire logic [2:0]                mux_channel,          // Selected pin
  input  wire logic [1:0]                mux_group,            // Selected group
  input  wire logic [1:0]                mux_source,           // Pin or extended
  output var  logic [ADCSS_RESULT_W-1:0] adc_code,             // Converted value
  output var  logic                      external_trigger_pin  // Trigger level
);
  logic [1:0] low_cnt = 2'h0;
  // Code carries source, group and channel so a misrouted result shows
  always_comb begin
    adc_code = {mux_source, mux_group, 3'h5, mux_channel};
  end
  // Idles high; a trigger is a three-cycle low pulse
  always @(posedge ref_clk) begin
    if (fire) begin
      low_cnt <= 2'h3;
    end else if (low_cnt != 2'h0) begin
      low_cnt <= low_cnt - 2'h1;
    end
  end
  assign external_trigger_pin = (low_cnt == 2'h0);
endmodule
`default_nettype wire

// ===== tb/adc_sweep_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module adc_sweep_sequencer_test
  import adcss_pkg::*;
;
  logic ref_clk = 1'b0, reset = 1'b1, start_write = 1'b0, start_wdata = 1'b0;
  logic ref_write = 1'b0, ref_wdata = 1'b0, trigger_select = 1'b0, fire = 1'b0;
  logic [1:0] op_mode = 2'h0, grp = 2'h0, pcnt = 2'h0, ext = 2'h0;
  logic [2:0] chan_select = 3'h0, result_rd_addr = 3'h0;
  logic res10 = 1'b0, sh = 1'b0, strobe_d = 1'b0, saw_op = 1'b0, pin, busy, flag, refc;
  logic sstrobe, opamp, rw;
  logic [9:0] code, rdata;
  logic [2:0] mch;
  logic [1:0] mgrp, msrc;
  logic [2:0] order_q[$];
  logic [2:0] exp_q[$];
  int n_fail = 0, n_checks = 0, i, k, np, busy_n = 0, rw_n = 0;
  // Short no-S&H lengths keep the run brief
  localparam int NOSH8  = 4;
  localparam int NOSH10 = 6;
  always #10 ref_clk = ~ref_clk;
  adcss_sweep_sequencer #(.NOSH_CYCLES_8(NOSH8), .NOSH_CYCLES_10(NOSH10)) dut (
    .ref_clk(ref_clk), .reset(reset), .start_write(start_write), .start_wdata(start_wdata),
    .ref_write(ref_write), .ref_wdata(ref_wdata), .trigger_select(trigger_select),
    .op_mode(op_mode), .chan_select(chan_select), .sweep_pin_count_hi(pcnt[1]),
    .sweep_pin_count_lo(pcnt[0]), .input_group_select_hi(grp[1]),
    .input_group_select_lo(grp[0]), .resolution_10bit(res10), .sample_hold_enable(sh),
    .ext_input_mode_hi(ext[1]), .ext_input_mode_lo(ext[0]), .external_trigger_pin(pin),
    .adc_code(code), .result_rd_addr(result_rd_addr), .conversion_result_n(rdata),
    .conversion_start_flag(flag), .reference_connect(refc), .busy(busy),
    .sample_strobe(sstrobe), .mux_channel(mch), .mux_group(mgrp), .mux_source(msrc),
    .opamp_route_out(opamp), .result_written(rw));
  adcss_far_side u_far (.ref_clk(ref_clk), .fire(fire), .mux_channel(mch),
    .mux_group(mgrp), .mux_source(msrc), .adc_code(code), .external_trigger_pin(pin));
  // Mux outputs lag the strobe by a cycle, so the channel is taken one edge later
  always @(posedge ref_clk) begin
    if (strobe_d) order_q.push_back(mch);
    if (opamp) saw_op = 1'b1;
    strobe_d <= sstrobe;
  end
  function automatic logic [9:0] exp_code(input logic [1:0] s, input logic [2:0] c);
    return {s, grp, 3'h5, c};
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic write_start(input logic v);
    start_write = 1'b1;
    start_wdata = v;
    step(1);
    start_write = 1'b0;
  endtask
  task automatic wait_low();
    busy_n = 0;
    rw_n = 0;
    for (k = 0; k < 400 && flag !== 1'b0; k++) begin
      step(1);
      if (busy === 1'b1) busy_n++;
      if (rw === 1'b1) rw_n++;
    end
    if (flag !== 1'b0) begin
      n_fail++;
      results();
    end
    step(2);
  endtask
  task automatic one_shot(input logic [2:0] ch, input logic [1:0] e, input int len);
    op_mode = ADCSS_MODE_ONE_SHOT;
    chan_select = ch;
    ext = e;
    saw_op = 1'b0;
    write_start(1'b1);
    wait_low();
    `CHK("conversion length", len, busy_n)
    `CHK("result strobes", 1, rw_n)
  endtask
  task automatic check_slot(input logic [2:0] a, input logic [9:0] e);
    result_rd_addr = a;
    step(1);
    `CHK("result", e, rdata)
  endtask
  initial begin
    step(12);
    reset = 1'b0;
    step(1);
    {start_write, start_wdata, ref_write, ref_wdata} = 4'hf;
    step(1);
    {start_write, ref_write} = 2'h0;
    `CHK("start flag", 1'b0, flag)
    step(50);
    `CHK("reference", 1'b1, refc)
    grp = 2'h2;
    sh = 1'b1;
    one_shot(3'h5, ADCSS_EXT_NONE, ADCSS_SH_CYCLES_8);
    check_slot(3'h5, exp_code(2'h0, 3'h5) & 10'h0ff);
    res10 = 1'b1;
    sh = 1'b0;
    one_shot(3'h3, ADCSS_EXT_NONE, NOSH10);
    check_slot(3'h3, exp_code(2'h0, 3'h3));
    for (i = 1; i < 4; i++) begin
      one_shot(3'h6, i[1:0], NOSH10);
      check_slot(i == 3 ? 3'h6 : i[2:0] - 3'h1, exp_code(i == 3 ? 2'h2 : i[1:0], 3'h6));
      `CHK("op-amp route", i == 3, saw_op)
    end
    ext = ADCSS_EXT_NONE;
    trigger_select = 1'b1;
    chan_select = 3'h4;
    write_start(1'b1);
    step(10);
    `CHK("busy before trigger", 1'b0, busy)
    fire = 1'b1;
    step(1);
    fire = 1'b0;
    wait_low();
    `CHK("trigger length", NOSH10, busy_n)
    check_slot(3'h4, exp_code(2'h0, 3'h4));
    trigger_select = 1'b0;
    for (i = 0; i < 4; i++) begin
      pcnt = i[1:0];
      // Every length pair, so the checker judges 28 and 33 cycle channels
      res10 = i[1];
      sh = i[0];
      op_mode = ADCSS_MODE_SWEEP1;
      order_q.delete();
      exp_q.delete();
      write_start(1'b1);
      // Busy rises one edge after the flag
      step(1);
      {ref_write, ref_wdata} = 2'h2;
      step(1);
      ref_write = 1'b0;
      `CHK("reference busy", 1'b1, refc)
      for (k = 0; k < 600 && order_q.size() < 10; k++) step(1);
      write_start(1'b0);
      step(3);
      `CHK("busy after clear", 1'b0, busy)
      np = i + 1;
      repeat (10) begin
        for (k = 0; k <= i; k++) exp_q.push_back(k[2:0]);
        exp_q.push_back(np[2:0]);
        np = (np == 7) ? i + 1 : np + 1;
      end
      if (order_q.size() < 10) begin
        n_fail++;
        results();
      end
      for (k = 0; k < 10; k++) `CHK("sweep channel", exp_q[k], order_q[k])
    end
    check_slot(3'h0, exp_code(2'h0, 3'h0));
    results();
  end
endmodule
`default_nettype wire
